// ==== src/lead_counter_timer_executor.sv ====
// lead_counter_timer_executor: runs control-lead, counter, timer and display instructions
// assumes a sequencer hands one instruction per issue pulse and waits for done
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (R1) tone-off silences alarm only after quarter second; extended level ends tone itself
// (R2) display-on enables receiver data display; default on until display-off
// (R3) programs at 50 kbps or faster must issue display-off
// (R4) each chain adds 25 characters; at most nine chains, 250 characters
// (R5) all-leads-off clears controlled leads except leads 6 and 20
// (R6) lead-on asserts one lead valid in current terminal or modem role
// (R7) lead-on argument 3 asserts every lead of the current role
// (R8) extended level maps argument 21 onto lead 22 for lead-on and lead-off
// (R9) lead-off clears named lead; argument 3 clears all role leads
// (R10) skip-if-lead-on skips next instruction when sampled lead is on
// (R11) skip-if-lead-off skips next instruction when sampled lead is off
// (R12) counters C and D hold 0 to 9999, preset from argument; only the preset is clamped, increment and decrement do not stop at 9999 or 0
// (R13) wait stalls given milliseconds; basic 9999 max, extended 65535, zero gives 65535; extended level loads larger arguments unclamped
// (R14) counters A and B preset 0 to 99; program start clears both
// (R15) increment and decrement act on counter A through L
// (R16) skip-if-zero skips next when counter A to D holds zero
// (R17) clear-timer zeroes and starts the up-counting interval timer
// (R18) set-timer loads 1 to 127 ms, or 0.1 to 9.9 s with decimal point
// (R19) set-timer skips next; expiry interrupts back to it; clear-timer cancels at basic level
// (R20) basic level shares one timer; extended level has two
// (R21) display-timer shows elapsed time wrapping at 12.7 s, or remaining time
// (R22) extended level store-timer copies interval timer into counter L
// (R23) reserved opcodes act as no-operation
module lead_counter_timer_executor import lead_exec_pkg::*; #(
  parameter int TONE_CYC = TONE_MIN_CYC,
  parameter int MS_CYC = CYC_PER_MS
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, active high
  input wire logic issue, // one-cycle instruction strobe
  input wire instr_t instr, // instruction with argument
  input wire logic extended, // extended level selected
  input wire logic modem_simulation_role, // 1 modem role, 0 terminal role
  input wire logic [NLEAD-1:0] lead_in, // sensed lead levels, async
  output logic done, // instruction complete pulse
  output result_t result, // outcome with done
  output logic [NLEAD-1:0] lead_out, // driven leads
  output logic tone, // alarm tone on
  output logic display_en, // receiver data display enabled
  output logic timer_irq, // countdown expired, resume skipped step
  output logic [16:0] timer_show, // display-timer value
  output logic [7:0] arg_len // current argument length
);
  logic [NLEAD-1:0] lead_r, lead_s1_r, lead_s2_r;
  logic done_r, tone_r, disp_r, irq_r;
  result_t res_r;
  logic [7:0] len_r;
  logic [3:0] nchain_r;
  logic [16:0] cnt_r [NCNT];
  logic [31:0] tone_cnt_r;
  logic tone_off_pend_r;
  logic wait_r;
  logic [16:0] wait_ms_r;
  logic [31:0] ms_div_r;
  logic ms_tick;
  logic [16:0] up_r, down_r; // ms counts
  logic down_run_r, up_run_r;
  logic [16:0] tmr_mode_show_r;
  logic show_down_r;
  logic [16:0] timer_now; // timer value shown or stored

  // map an argument lead number onto the lead vector
  function automatic logic [NLEAD-1:0] lead_bit(input logic [4:0] n, input logic ext);
    logic [NLEAD-1:0] b;
    b = '0;
    unique case (n)
      LD_4: b[B4] = 1'b1;
      LD_20: b[B20] = 1'b1;
      LD_11: b[B11] = 1'b1;
      LD_5: b[B5] = 1'b1;
      LD_6: b[B6] = 1'b1;
      LD_8: b[B8] = 1'b1;
      LD_22: b[B22] = 1'b1;
      LD_18: b[B18] = 1'b1;
      LD_21: b[B22] = ext; // [R8]
      default: b = '0;
    endcase
    return b;
  endfunction : lead_bit

  logic [NLEAD-1:0] role_mask, sel_bit, sel_any;
  logic [4:0] lead_arg;
  assign role_mask = modem_simulation_role ? DCE_MASK : DTE_MASK;
  assign lead_arg = instr.value[4:0];
  assign sel_bit = lead_bit(lead_arg, extended) & role_mask; // [R6]
  assign sel_any = lead_bit(lead_arg, extended);
  assign ms_tick = (ms_div_r == 32'(MS_CYC - 1));

  // input synchroniser for sensed leads
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lead_s1_r <= '0;
      lead_s2_r <= '0;
    end else begin
      lead_s1_r <= lead_in;
      lead_s2_r <= lead_s1_r;
    end
  end

  // millisecond prescaler
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ms_div_r <= '0;
    end else if (ms_tick) begin
      ms_div_r <= '0;
    end else begin
      ms_div_r <= ms_div_r + 32'd1;
    end
  end

  // driven leads
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lead_r <= '0;
    end else if (issue) begin
      unique case (instr.opcode)
        OP_ALL_OFF: lead_r <= lead_r & KEEP_MASK; // [R5]
        OP_LEAD_ON: begin
          if (lead_arg == LD_ALL) begin
            lead_r <= lead_r | role_mask; // [R7]
          end else begin
            lead_r <= lead_r | sel_bit; // [R6] [R8]
          end
        end
        OP_LEAD_OFF: begin
          if (lead_arg == LD_ALL) begin
            lead_r <= lead_r & ~role_mask; // [R9]
          end else begin
            lead_r <= lead_r & ~sel_bit; // [R9] [R8]
          end
        end
        default: lead_r <= lead_r; // [R23]
      endcase
    end
  end

  // alarm tone with minimum on time
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tone_r <= 1'b0;
      tone_cnt_r <= '0;
      tone_off_pend_r <= 1'b0;
    end else if (issue && instr.opcode == OP_TONE_ON) begin
      tone_r <= 1'b1;
      tone_cnt_r <= '0;
      tone_off_pend_r <= 1'b0;
    end else if (tone_r) begin
      if (tone_cnt_r < 32'(TONE_CYC)) begin
        tone_cnt_r <= tone_cnt_r + 32'd1;
      end
      if (issue && instr.opcode == OP_TONE_OFF) begin
        tone_off_pend_r <= 1'b1;
      end
      if (tone_cnt_r >= 32'(TONE_CYC - 1) &&
          (extended || tone_off_pend_r || (issue && instr.opcode == OP_TONE_OFF))) begin
        tone_r <= 1'b0; // [R1]
        tone_off_pend_r <= 1'b0;
      end
    end
  end

  // receiver data display gate
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      disp_r <= 1'b1; // [R2]
    end else if (issue && instr.opcode == OP_DISP_ON) begin
      disp_r <= 1'b1; // [R2]
    end else if (issue && instr.opcode == OP_DISP_OFF) begin
      disp_r <= 1'b0; // [R3]
    end
  end

  // argument chaining
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      len_r <= CHAIN_STEP;
      nchain_r <= '0;
    end else if (issue) begin
      if (instr.opcode == OP_CHAIN) begin
        if (nchain_r < MAX_CHAIN) begin
          nchain_r <= nchain_r + 4'd1;
          len_r <= len_r + CHAIN_STEP; // [R4]
        end
      end else begin
        nchain_r <= '0;
        len_r <= CHAIN_STEP;
      end
    end
  end

  // counters A to L
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCNT; i++) begin
        cnt_r[i] <= '0;
      end
    end else if (issue) begin
      unique case (instr.opcode)
        OP_START: begin
          cnt_r[0] <= '0; // [R14]
          cnt_r[1] <= '0; // [R14]
        end
        OP_SET_A: cnt_r[0] <= (instr.value > 17'(AB_MAX)) ? 17'(AB_MAX) : instr.value; // [R14]
        OP_SET_B: cnt_r[1] <= (instr.value > 17'(AB_MAX)) ? 17'(AB_MAX) : instr.value; // [R14]
        OP_SET_C: cnt_r[2] <= (instr.value > 17'(CD_MAX)) ? 17'(CD_MAX) : instr.value; // [R12]
        OP_SET_D: cnt_r[3] <= (instr.value > 17'(CD_MAX)) ? 17'(CD_MAX) : instr.value; // [R12]
        OP_INC: if (instr.letter < 4'(NCNT)) begin
          cnt_r[instr.letter] <= cnt_r[instr.letter] + 17'd1; // [R15]
        end
        OP_DEC: if (instr.letter < 4'(NCNT)) begin
          cnt_r[instr.letter] <= cnt_r[instr.letter] - 17'd1; // [R15]
        end
        OP_STORE_TMR: if (extended) begin
          cnt_r[NCNT-1] <= timer_now; // [R22]
        end
        default: cnt_r[0] <= cnt_r[0]; // [R23]
      endcase
    end
  end

  // wait instruction
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_r <= 1'b0;
      wait_ms_r <= '0;
    end else if (issue && instr.opcode == OP_WAIT) begin
      wait_r <= 1'b1;
      if (instr.value == '0) begin
        wait_ms_r <= WAIT_ZERO; // [R13]
      end else if (!extended && instr.value > WAIT_BASIC_MAX) begin
        wait_ms_r <= WAIT_BASIC_MAX; // [R13]
      end else begin
        wait_ms_r <= instr.value; // [R13]
      end
    end else if (wait_r && ms_tick) begin
      if (wait_ms_r <= 17'd1) begin
        wait_r <= 1'b0;
      end
      wait_ms_r <= wait_ms_r - 17'd1;
    end
  end

  // set-timer countdown length in ms
  logic [16:0] set_ms;
  always_comb begin
    set_ms = '0;
    if (instr.point) begin
      set_ms = 17'((instr.value > 17'(SEC_SET_MAX) ? 17'(SEC_SET_MAX) : instr.value) *
                   TENTH_MS); // [R18]
    end else begin
      set_ms = (instr.value > 17'(MS_RANGE_MAX)) ? 17'(MS_RANGE_MAX) : instr.value; // [R18]
    end
  end

  logic [16:0] up_wrap;
  assign up_wrap = 17'(17'(MS_RANGE_MAX) * TENTH_MS); // 12.7 s
  assign timer_now = show_down_r ? down_r : up_r;

  // interval timers; basic level shares, extended separates
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      up_r <= '0;
      up_run_r <= 1'b0;
      down_r <= '0;
      down_run_r <= 1'b0;
      irq_r <= 1'b0;
      show_down_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      if (issue && instr.opcode == OP_CLR_TMR) begin
        up_r <= '0; // [R17]
        up_run_r <= 1'b1;
        show_down_r <= 1'b0;
        if (!extended) begin
          down_run_r <= 1'b0; // [R19] [R20]
        end
      end else if (issue && instr.opcode == OP_SET_TMR) begin
        down_r <= set_ms; // [R18]
        down_run_r <= (set_ms != '0);
        show_down_r <= 1'b1;
        if (!extended) begin
          up_run_r <= 1'b0; // [R20]
        end
      end else begin
        if (up_run_r && ms_tick) begin
          up_r <= (up_r >= up_wrap) ? 17'd0 : up_r + 17'd1; // [R21]
        end
        if (down_run_r && ms_tick) begin
          down_r <= down_r - 17'd1;
          if (down_r == 17'd1) begin
            down_run_r <= 1'b0;
            irq_r <= 1'b1; // [R19]
          end
        end
      end
    end
  end

  // display-timer value, latched on instruction
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tmr_mode_show_r <= '0;
    end else if (issue && instr.opcode == OP_SHOW_TMR) begin
      tmr_mode_show_r <= timer_now; // [R21]
    end
  end

  // completion and skip outcome
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
      res_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (wait_r && ms_tick && wait_ms_r <= 17'd1) begin
        done_r <= 1'b1;
        res_r <= '0;
      end else if (issue && instr.opcode != OP_WAIT) begin
        done_r <= 1'b1;
        res_r <= '0;
        unique case (instr.opcode)
          OP_SKIP_ON: res_r.skip <= |(sel_any & lead_s2_r); // [R10]
          OP_SKIP_OFF: res_r.skip <= ~|(sel_any & lead_s2_r); // [R11]
          OP_SKIP_ZERO: res_r.skip <= (instr.letter < 4'd4) &&
                                      (cnt_r[instr.letter] == '0); // [R16]
          OP_SET_TMR: res_r.skip <= 1'b1; // [R19]
          OP_CHAIN: res_r.chain_err <= (nchain_r >= MAX_CHAIN); // [R4]
          default: res_r <= '0; // [R23]
        endcase
      end
    end
  end

  assign done = done_r;
  assign result = res_r;
  assign lead_out = lead_r;
  assign tone = tone_r;
  assign display_en = disp_r;
  assign timer_irq = irq_r;
  assign timer_show = tmr_mode_show_r;
  assign arg_len = len_r;
endmodule : lead_counter_timer_executor
`default_nettype wire

// ==== src/lead_exec_pkg.sv ====
// lead_exec_pkg: opcodes, lead positions, timing counts and carrier types
// assumes a 100 MHz system clock and two-digit decimal opcodes in bcd-free binary
package lead_exec_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TONE_MIN_MS = 250; // quarter second
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int TONE_MIN_CYC = TONE_MIN_MS * CYC_PER_MS;
  // opcodes
  localparam logic [6:0] OP_START = 7'h01;
  localparam logic [6:0] OP_TONE_ON = 7'h22; // 34
  localparam logic [6:0] OP_TONE_OFF = 7'h23; // 35
  localparam logic [6:0] OP_DISP_ON = 7'h24; // 36
  localparam logic [6:0] OP_DISP_OFF = 7'h25; // 37
  localparam logic [6:0] OP_CHAIN = 7'h26; // 38
  localparam logic [6:0] OP_ALL_OFF = 7'h28; // 40
  localparam logic [6:0] OP_LEAD_ON = 7'h29; // 41
  localparam logic [6:0] OP_LEAD_OFF = 7'h2A; // 42
  localparam logic [6:0] OP_SKIP_ON = 7'h2B; // 43
  localparam logic [6:0] OP_SKIP_OFF = 7'h2C; // 44
  localparam logic [6:0] OP_SET_C = 7'h2D; // 45
  localparam logic [6:0] OP_SET_D = 7'h2E; // 46
  localparam logic [6:0] OP_WAIT = 7'h32; // 50
  localparam logic [6:0] OP_SET_A = 7'h33; // 51
  localparam logic [6:0] OP_SET_B = 7'h34; // 52
  localparam logic [6:0] OP_INC = 7'h35; // 53
  localparam logic [6:0] OP_DEC = 7'h36; // 54
  localparam logic [6:0] OP_SKIP_ZERO = 7'h38; // 56
  localparam logic [6:0] OP_CLR_TMR = 7'h39; // 57
  localparam logic [6:0] OP_SET_TMR = 7'h3A; // 58
  localparam logic [6:0] OP_SHOW_TMR = 7'h3B; // 59
  localparam logic [6:0] OP_STORE_TMR = 7'h3C; // 60
  // lead numbers
  localparam logic [4:0] LD_ALL = 5'h03;
  localparam logic [4:0] LD_4 = 5'h04;
  localparam logic [4:0] LD_5 = 5'h05;
  localparam logic [4:0] LD_6 = 5'h06;
  localparam logic [4:0] LD_8 = 5'h08;
  localparam logic [4:0] LD_11 = 5'h0B;
  localparam logic [4:0] LD_18 = 5'h12;
  localparam logic [4:0] LD_20 = 5'h14;
  localparam logic [4:0] LD_21 = 5'h15;
  localparam logic [4:0] LD_22 = 5'h16;
  // lead vector bit positions
  localparam int B4 = 0;
  localparam int B20 = 1;
  localparam int B11 = 2;
  localparam int B5 = 3;
  localparam int B6 = 4;
  localparam int B8 = 5;
  localparam int B22 = 6;
  localparam int B18 = 7;
  localparam int NLEAD = 8;
  localparam logic [7:0] DTE_MASK = 8'h07;
  localparam logic [7:0] DCE_MASK = 8'hF8;
  localparam logic [7:0] KEEP_MASK = 8'h12; // leads 6 and 20
  localparam logic [3:0] MAX_CHAIN = 4'h9;
  localparam logic [7:0] CHAIN_STEP = 8'h19; // 25 characters
  localparam logic [6:0] AB_MAX = 7'h63; // 99
  localparam logic [13:0] CD_MAX = 14'h270F; // 9999
  localparam logic [16:0] WAIT_BASIC_MAX = 17'h0270F;
  localparam logic [16:0] WAIT_ZERO = 17'h0FFFF; // 65535
  localparam logic [6:0] MS_RANGE_MAX = 7'h7F; // 127 ms / 12.7 s
  localparam logic [6:0] SEC_SET_MAX = 7'h63; // 9.9 s in tenths
  localparam logic [16:0] TENTH_MS = 17'h00064; // 100 ms
  localparam int NCNT = 12;

  // one instruction as handed to the executor
  typedef struct packed {
    logic [6:0] opcode;
    logic [16:0] value; // numeric argument
    logic [3:0] letter; // counter select, 0 = A
    logic point; // argument had a decimal point
  } instr_t;

  // result of one instruction
  typedef struct packed {
    logic skip; // skip next instruction
    logic chain_err; // chain limit exceeded
  } result_t;
endpackage : lead_exec_pkg

// ==== testbench/lead_exec_monitor.sv ====
// lead_exec_monitor: port-level assertions for the instruction executor
// assumes binding onto lead_counter_timer_executor with its tone parameter
`timescale 1ns/10ps
`default_nettype none
module lead_exec_monitor import lead_exec_pkg::*; #(
  parameter int TONE_CYC = TONE_MIN_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset
  input wire logic issue, // instruction strobe
  input wire instr_t instr, // instruction
  input wire logic extended, // extended level
  input wire logic modem_simulation_role, // role select
  input wire logic done, // completion pulse
  input wire result_t result, // outcome
  input wire logic [NLEAD-1:0] lead_out, // driven leads
  input wire logic tone, // alarm
  input wire logic display_en, // display gate
  input wire logic [7:0] arg_len // argument length
);
  logic [31:0] tone_cnt_r;
  logic [7:0] role_mask;
  // cycles the alarm has sounded without a break
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tone_cnt_r <= '0;
    end else begin
      tone_cnt_r <= tone ? tone_cnt_r + 32'h1 : '0;
    end
  end
  // leads owned by the current role
  assign role_mask = modem_simulation_role ? DCE_MASK : DTE_MASK;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_take(logic [6:0] op);
    issue && instr.opcode == op;
  endsequence
  a_done_follows: assert property (issue && instr.opcode != OP_WAIT |=> done)
    else $error("done missing after instruction");
  a_lead_single_on: assert property (s_take(OP_LEAD_ON) ##0 (!modem_simulation_role &&
    instr.value == 17'h00004) |=> lead_out[B4]) else $error("lead 4 not set");
  a_lead_all_on: assert property (s_take(OP_LEAD_ON) ##0 (instr.value == 17'h00003)
    |=> (lead_out & role_mask) == role_mask) else $error("role leads not all on");
  a_lead_all_off: assert property (s_take(OP_LEAD_OFF) ##0 (instr.value == 17'h00003)
    |=> (lead_out & role_mask) == 8'h00) else $error("role leads not all off");
  a_all_off_keep: assert property (s_take(OP_ALL_OFF)
    |=> lead_out == ($past(lead_out) & KEEP_MASK)) else $error("all-off kept wrong leads");
  a_lead_alias: assert property (s_take(OP_LEAD_ON) ##0 (extended && modem_simulation_role &&
    instr.value == 17'h00015) |=> lead_out[B22]) else $error("lead 21 alias failed");
  a_chain_grow: assert property (s_take(OP_CHAIN) ##0 (arg_len < 8'hFA)
    |=> arg_len == $past(arg_len) + CHAIN_STEP && !result.chain_err) else $error("chain step");
  a_chain_cap: assert property (s_take(OP_CHAIN) ##0 (arg_len == 8'hFA)
    |=> result.chain_err && arg_len == 8'hFA) else $error("chain limit not held");
  a_disp_cause: assert property ($fell(display_en) |-> $past(issue &&
    instr.opcode == OP_DISP_OFF)) else $error("display dropped without display-off");
  a_timer_skip: assert property (s_take(OP_SET_TMR) |=> done && result.skip)
    else $error("set-timer did not skip");
  a_tone_min: assert property ($fell(tone) |-> tone_cnt_r >= TONE_CYC)
    else $error("tone shorter than minimum");
endmodule : lead_exec_monitor
bind lead_counter_timer_executor lead_exec_monitor #(.TONE_CYC(TONE_CYC)) u_lead_exec_monitor (
  .clk_sys(clk_sys), .reset(reset), .issue(issue), .instr(instr), .extended(extended),
  .modem_simulation_role(modem_simulation_role), .done(done), .result(result),
  .lead_out(lead_out), .tone(tone), .display_en(display_en), .arg_len(arg_len));
`default_nettype wire

// ==== testbench/rs232_circuit_model.sv ====
// rs232_circuit_model: circuit under test seen across the interface leads
// assumes leads loop back through the cable, plus leads the circuit raises itself
`timescale 1ns/10ps
`default_nettype none
module rs232_circuit_model import lead_exec_pkg::*; (
  input wire logic [NLEAD-1:0] lead_out, // leads driven by the executor
  input wire logic [NLEAD-1:0] far_on, // leads the circuit asserts itself
  output logic [NLEAD-1:0] lead_in // levels sensed at the connector
);
  // cable loopback with a short propagation delay, not clock aligned
  assign #3 lead_in = lead_out | far_on;
endmodule : rs232_circuit_model
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: directed instruction sequences for the lead, counter and timer executor
// assumes shortened tone and millisecond counts, inputs driven on falling edges
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lead_exec_pkg::*;
  localparam int TONE_T = 100; // shortened quarter second
  localparam int MS_T = 10; // shortened millisecond
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic issue = 1'b0;
  instr_t instr = '0;
  logic extended = 1'b0;
  logic modem_simulation_role = 1'b0;
  logic [NLEAD-1:0] far_on = '0;
  logic [NLEAD-1:0] lead_in;
  logic [NLEAD-1:0] lead_out;
  logic done, tone, display_en, timer_irq;
  result_t result, res;
  logic [16:0] timer_show;
  logic [7:0] arg_len;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int irq_n = 0;
  int lat, k;
  lead_counter_timer_executor #(.TONE_CYC(TONE_T), .MS_CYC(MS_T)) u_lead_counter_timer_executor (
    .clk_sys(clk_sys), .reset(reset), .issue(issue), .instr(instr), .extended(extended),
    .modem_simulation_role(modem_simulation_role), .lead_in(lead_in), .done(done),
    .result(result), .lead_out(lead_out), .tone(tone), .display_en(display_en),
    .timer_irq(timer_irq), .timer_show(timer_show), .arg_len(arg_len));
  rs232_circuit_model u_rs232_circuit_model (.lead_out(lead_out), .far_on(far_on),
    .lead_in(lead_in));
  // clock
  always #5 clk_sys = ~clk_sys;
  // cycle count, expiry pulses and hang cutoff
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (timer_irq === 1'b1) begin
      irq_n <= irq_n + 1;
    end
    if (cyc == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // issue one instruction and wait for its done pulse
  task automatic exec(input logic [6:0] op, input logic [16:0] v, input logic [3:0] l = 4'h0,
      input logic p = 1'b0);
    int n;
    repeat (3) @(negedge clk_sys);
    issue = 1'b1;
    instr = {op, v, l, p};
    @(negedge clk_sys);
    issue = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    lat = n;
    res = result;
  endtask : exec
  task automatic lead(input logic [6:0] op, input logic [4:0] n, input logic [7:0] exp);
    exec(op, {12'h000, n});
    check("lead_out", {9'h000, exp}, {9'h000, lead_out});
  endtask : lead
  task automatic skip(input logic [6:0] op, input logic [16:0] v, input logic [3:0] l,
      input logic exp);
    exec(op, v, l);
    check("skip", {16'h0000, exp}, {16'h0000, res.skip});
  endtask : skip
  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    check("display_en", 17'h1, display_en);
    check("arg_len", 17'h19, arg_len);
    lead(OP_LEAD_ON, LD_4, 8'h01);
    lead(OP_LEAD_ON, LD_5, 8'h01);
    lead(OP_LEAD_ON, LD_ALL, 8'h07);
    lead(OP_LEAD_OFF, LD_11, 8'h03);
    far_on = 8'h20;
    skip(OP_SKIP_ON, LD_20, 4'h0, 1'b1);
    skip(OP_SKIP_ON, LD_8, 4'h0, 1'b1);
    skip(OP_SKIP_ON, LD_6, 4'h0, 1'b0);
    skip(OP_SKIP_OFF, LD_4, 4'h0, 1'b0);
    skip(OP_SKIP_OFF, LD_6, 4'h0, 1'b1);
    far_on = 8'h00;
    lead(OP_ALL_OFF, 5'h00, 8'h02);
    lead(7'h27, LD_4, 8'h02);
    modem_simulation_role = 1'b1;
    extended = 1'b1;
    lead(OP_LEAD_ON, LD_ALL, 8'hFA);
    lead(OP_LEAD_OFF, LD_ALL, 8'h02);
    lead(OP_LEAD_ON, LD_21, 8'h42);
    lead(OP_LEAD_ON, LD_6, 8'h52);
    lead(OP_ALL_OFF, 5'h00, 8'h12);
    exec(OP_SET_A, 17'h00000);
    skip(OP_SKIP_ZERO, 17'h0, 4'h0, 1'b1);
    exec(OP_INC, 17'h0, 4'h0);
    skip(OP_SKIP_ZERO, 17'h0, 4'h0, 1'b0);
    exec(OP_DEC, 17'h0, 4'h0);
    skip(OP_SKIP_ZERO, 17'h0, 4'h0, 1'b1);
    exec(OP_SET_C, 17'h0270F);
    skip(OP_SKIP_ZERO, 17'h0, 4'h2, 1'b0);
    exec(OP_SET_D, 17'h00000);
    skip(OP_SKIP_ZERO, 17'h0, 4'h3, 1'b1);
    exec(OP_SET_B, 17'h00005);
    exec(OP_START, 17'h00000);
    skip(OP_SKIP_ZERO, 17'h0, 4'h1, 1'b1);
    for (k = 1; k <= 9; k++) begin
      exec(OP_CHAIN, 17'h0);
      check("arg_len", 17'(25 + 25 * k), arg_len);
    end
    exec(OP_CHAIN, 17'h0);
    check("chain_err", 17'h1, res.chain_err);
    check("arg_len", 17'hFA, arg_len);
    exec(OP_DISP_OFF, 17'h0);
    check("display_en", 17'h0, display_en);
    exec(OP_DISP_ON, 17'h0);
    check("display_en", 17'h1, display_en);
    extended = 1'b0;
    exec(OP_TONE_ON, 17'h0);
    exec(OP_TONE_OFF, 17'h0);
    check("tone", 17'h1, tone);
    repeat (TONE_T) @(negedge clk_sys);
    check("tone", 17'h0, tone);
    extended = 1'b1;
    exec(OP_TONE_ON, 17'h0);
    repeat (TONE_T + 10) @(negedge clk_sys);
    check("tone", 17'h0, tone);
    exec(OP_WAIT, 17'h00003);
    check("wait_len", 17'h1, lat >= 2 * MS_T && lat <= 4 * MS_T + 3);
    extended = 1'b0;
    k = irq_n;
    exec(OP_SET_TMR, 17'h00005);
    repeat (80) @(negedge clk_sys);
    check("irq_count", 17'h1, irq_n - k);
    k = irq_n;
    exec(OP_SET_TMR, 17'h00005);
    exec(OP_CLR_TMR, 17'h0);
    repeat (80) @(negedge clk_sys);
    check("irq_count", 17'h0, irq_n - k);
    exec(OP_SHOW_TMR, 17'h0);
    check("timer_show", 17'h1, timer_show >= 7 && timer_show <= 10);
    k = irq_n;
    exec(OP_SET_TMR, 17'h00001, 4'h0, 1'b1);
    repeat (900) @(negedge clk_sys);
    check("irq_count", 17'h0, irq_n - k);
    repeat (200) @(negedge clk_sys);
    check("irq_count", 17'h1, irq_n - k);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
